/* File: logic/ifb_fetch_ctrl.sv */
// Instruction issue sequencer, counter and fetch request control
// Summary of operation
// - each decode cycle but the last copies the two selected halfwords into instr_op_reg
// - decode works from instr_op_reg and feeds base and index to adder
// - address phase entry loads adder into storage reg unless RR, and into jump target reg for branch and execute
// - address phase latches register operands onto operand_bus_latch
// - op code handed to execution at last address cycle unless interrupted
// - address phase decodes from both instr_op_reg and buffer_op_reg
// - either phase stretches while its start conditions are unmet
// - exec_op_reg loads from buffer_op_reg; last_cycle_op_reg in last cycle
// - 24-bit seq_count_reg with its lowest address bit always zero
// - gate select bits advance per instruction, upper bits by incrementer
// - gate selector picks which fetch_pair halfwords feed instr_op_reg
// - next instruction address is counter plus instruction length
// - fetch on empty buffer; blocked unacknowledged fetch cancelled
// - sequential fetches forced normally, suppressed when branch expected
// - fetch increment from counter and empty buffer; bit20 names buffer
// - branch request at address phase entry; bit20 names return buffer
// - successor fetch address made in address phase, issued at hand-off
// - outcome trigger set during branch test; success line valid then
// - early branch data waits in landing reg; late data goes to buffer
// - successor data kept if it returns after a successful outcome, dropped otherwise
// - success loads counter from jump target; failure resumes at once
// - execute acts as branch without counter change, then recovery cycle
`timescale 1ns/1ps
module ifb_fetch_ctrl (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              ic_load,
    input  wire logic [23:0]       ic_load_addr,
    input  wire logic              intr_pending,
    input  wire logic              exec_ready,
    input  wire logic              exec_last,
    input  wire logic              exec_block,
    input  wire logic              tests_done,
    input  wire logic              branch_ok,
    output logic [3:0]             base_sel,
    output logic [3:0]             index_sel,
    input  wire logic [23:0]       base_data,
    input  wire logic [23:0]       index_data,
    output logic [3:0]             opnd_sel,
    output logic                   opnd_float,
    input  wire logic [63:0]       opnd_data,
    output logic                   req_valid,
    output ifb_pkg::ifb_kind_t     req_kind,
    output logic [23:0]            req_addr,
    output logic                   req_buf,
    input  wire logic              req_ack,
    input  wire logic              ret_valid,
    input  wire ifb_pkg::ifb_kind_t ret_kind,
    input  wire logic              ret_buf,
    input  wire logic [63:0]       ret_data,
    output logic                   decode_phase,
    output logic                   address_phase,
    output logic                   address_phase_entry,
    output logic                   exec_start,
    output logic [7:0]             exec_op,
    output logic [7:0]             last_cycle_op,
    output logic                   outcome_ready,
    output logic [23:0]            storage_addr,
    output logic [63:0]            operand_bus_latch,
    output logic [23:0]            seq_count
);
    import ifb_pkg::*;

    function automatic logic [31:0] pick(input logic [63:0] a,
                                         input logic [63:0] b,
                                         input logic [2:0]  g);
        logic [127:0] ab;
        logic [2:0]   g1;
        ab = {a, b};
        g1 = g + 3'h1;
        return {ab[127-16*g -: 16], ab[127-16*g1 -: 16]};
    endfunction

    function automatic logic [2:0] ilen(input logic [7:0] op);
        case (op[7:6])
            2'h0:    return LEN_RR;
            2'h3:    return LEN_SS;
            default: return LEN_RX;
        endcase
    endfunction

    function automatic ifb_class_t op_class(input logic [7:0] op);
        if (op == OP_EX)
            return C_EX;
        if (op == OP_BAL || op == OP_BCT || op == OP_BC)
            return C_BR;
        return (op[7:6] == 2'h0) ? C_RR : C_RX;
    endfunction

    // Gate select adder on the halfword bits, carry into the incrementer
    function automatic logic [23:0] adv(input logic [23:0] c,
                                        input logic [2:0]  l);
        logic [3:0]  s;
        logic [19:0] up;
        s  = {1'b0, c[GS_HI:GS_LO]} + {2'h0, l[2:1]};
        up = c[AW-1:UP_LO] + {19'h0, s[3]};
        return {up, s[2:0], 1'b0};
    endfunction

    ifb_state_t  state_q, state_d;
    logic [63:0] buf_q [2];
    logic [63:0] buf_d [2];
    logic [1:0]  bval_q, bval_d, sbusy_q, sbusy_d;
    logic [63:0] land_q, land_d, obl_q, obl_d;
    logic        land_v_q, land_v_d, iop_ok_q, iop_ok_d;
    logic [31:0] instr_op_reg_q, instr_op_reg_d;
    logic [7:0]  buffer_op_reg_q, buffer_op_reg_d;
    logic [7:0]  exec_op_reg_q, exec_op_reg_d;
    logic [7:0]  last_cycle_op_reg_q, last_cycle_op_reg_d;
    logic [23:0] seq_count_reg_q, seq_count_reg_d;
    logic [23:0] jt_q, jt_d, sar_q, sar_d;
    logic [23:0] op_addr_q, op_addr_d, succ_addr_q, succ_addr_d;
    logic [23:0] rq_addr_q, rq_addr_d;
    logic        op_pend_q, op_pend_d, succ_pend_q, succ_pend_d;
    logic        rq_v_q, rq_v_d, rq_buf_q, rq_buf_d;
    ifb_kind_t   op_kind_q, op_kind_d, rq_kind_q, rq_kind_d;
    logic        entry_q, entry_d, is_ex_q, is_ex_d;
    logic        ex_mode_q, ex_mode_d, br_dir_q, br_dir_d;
    logic        s_take_q, s_take_d;
    logic [2:0]  ex_len_q, ex_len_d;
    logic [31:0] pick_n;
    logic [23:0] ea, nxt, seq_a;
    logic [7:0]  cur_op;
    ifb_class_t  cur_cls;
    logic [2:0]  gsel, gsel1;
    logic        ready, seq_want, seq_issue, seq_tgt;
    logic        start_c, outc_c;

    assign gsel    = seq_count_reg_q[GS_HI:GS_LO];
    assign gsel1   = gsel + 3'h1;
    assign pick_n  = pick(buf_q[0], buf_q[1], gsel);
    assign ready   = ex_mode_q ? land_v_q :
                     bval_q[gsel[2]] && (ilen(pick_n[31:24]) == LEN_RR
                                         || bval_q[gsel1[2]]);
    assign base_sel  = instr_op_reg_q[15:12];
    assign index_sel = instr_op_reg_q[19:16];
    assign opnd_sel  = instr_op_reg_q[23:20];
    assign ea = (base_sel != 4'h0 ? base_data : 24'h0)
              + (index_sel != 4'h0 ? index_data : 24'h0)
              + {12'h0, instr_op_reg_q[11:0]};
    assign cur_op  = entry_q ? instr_op_reg_q[31:24]
                             : buffer_op_reg_q;
    assign cur_cls = op_class(cur_op);
    assign opnd_float = ~cur_op[7] & cur_op[5];
    assign nxt     = adv(seq_count_reg_q, ilen(buffer_op_reg_q));
    // Empty buffer to refill: the current one first, else the other
    assign seq_tgt = bval_q[seq_count_reg_q[BUF_BIT]]
                   ? ~seq_count_reg_q[BUF_BIT]
                   : seq_count_reg_q[BUF_BIT];
    assign seq_a = (seq_tgt | ~seq_count_reg_q[BUF_BIT])
                 ? {seq_count_reg_q[23:4], seq_tgt, 3'h0}
                 : {seq_count_reg_q[23:4] + 20'h1, 1'b0, 3'h0};
    assign seq_want = !bval_q[seq_tgt] && !sbusy_q[seq_tgt]
                   && !exec_block && !ex_mode_q
                   && state_q != S_IDLE && state_q != S_BRW
                   && !(state_q == S_ADR
                        && (cur_cls == C_BR || cur_cls == C_EX));

    always_comb
    begin
        state_d = state_q;          buf_d = buf_q;
        bval_d = bval_q;            sbusy_d = sbusy_q;
        land_d = land_q;            land_v_d = land_v_q;
        obl_d = obl_q;              iop_ok_d = iop_ok_q;
        instr_op_reg_d = instr_op_reg_q;
        buffer_op_reg_d = buffer_op_reg_q;
        exec_op_reg_d = exec_op_reg_q;
        last_cycle_op_reg_d = last_cycle_op_reg_q;
        seq_count_reg_d = seq_count_reg_q;
        jt_d = jt_q;                sar_d = sar_q;
        op_addr_d = op_addr_q;      succ_addr_d = succ_addr_q;
        op_pend_d = op_pend_q;      succ_pend_d = succ_pend_q;
        op_kind_d = op_kind_q;      entry_d = entry_q;
        rq_v_d = rq_v_q;            rq_kind_d = rq_kind_q;
        rq_addr_d = rq_addr_q;      rq_buf_d = rq_buf_q;
        is_ex_d = is_ex_q;          ex_mode_d = ex_mode_q;
        br_dir_d = br_dir_q;        s_take_d = s_take_q;
        ex_len_d = ex_len_q;
        start_c = 1'b0;             outc_c = 1'b0;
        seq_issue = 1'b0;
        if (rq_v_q && req_ack)
            rq_v_d = 1'b0;
        if (rq_v_q && rq_kind_q == K_SEQ && exec_block && !req_ack)
        begin
            rq_v_d = 1'b0;
            sbusy_d[rq_buf_q] = 1'b0;
        end
        if (ret_valid)
        begin
            case (ret_kind)
                K_SEQ:
                begin
                    buf_d[ret_buf] = ret_data;
                    bval_d[ret_buf] = 1'b1;
                    sbusy_d[ret_buf] = 1'b0;
                end
                K_BR:
                    if (br_dir_q)
                    begin
                        buf_d[ret_buf] = ret_data;
                        bval_d[ret_buf] = 1'b1;
                        br_dir_d = 1'b0;
                    end
                    else
                    begin
                        land_d = ret_data;
                        land_v_d = 1'b1;
                    end
                K_SUCC:
                begin
                    if (s_take_q)
                    begin
                        buf_d[ret_buf] = ret_data;
                        bval_d[ret_buf] = 1'b1;
                    end
                    s_take_d = 1'b0;
                end
                default: ;
            endcase
        end
        if (exec_last)
            last_cycle_op_reg_d = exec_op_reg_q;
        case (state_q)
            S_DEC:
                if (iop_ok_q)
                begin
                    state_d = S_ADR;
                    entry_d = 1'b1;
                    iop_ok_d = 1'b0;
                end
                else
                begin
                    instr_op_reg_d = ex_mode_q
                        ? pick(land_q, land_q, {1'b0, jt_q[2:1]})
                        : pick_n;
                    iop_ok_d = ready;
                end
            S_ADR:
            begin
                obl_d = opnd_data;
                if (entry_q)
                begin
                    entry_d = 1'b0;
                    buffer_op_reg_d = instr_op_reg_q[31:24];
                    if (cur_cls != C_RR)
                    begin
                        sar_d = ea;
                        op_pend_d = 1'b1;
                        op_addr_d = ea;
                        op_kind_d = K_OPND;
                    end
                    if (cur_cls == C_BR || cur_cls == C_EX)
                    begin
                        jt_d = ea;
                        op_kind_d = K_BR;
                        land_v_d = 1'b0;
                        succ_addr_d = {ea[23:3] + 21'h1, 3'h0};
                    end
                end
                else if (!op_pend_q && exec_ready)
                begin
                    if (intr_pending)
                        state_d = S_IDLE;
                    else
                    begin
                        start_c = 1'b1;
                        exec_op_reg_d = buffer_op_reg_q;
                        state_d = S_DEC;
                        if (cur_cls == C_BR)
                        begin
                            succ_pend_d = 1'b1;
                            is_ex_d = 1'b0;
                            state_d = S_BRW;
                        end
                        else if (cur_cls == C_EX)
                        begin
                            is_ex_d = 1'b1;
                            ex_len_d = ilen(buffer_op_reg_q);
                            state_d = S_BRW;
                        end
                        else if (ex_mode_q)
                        begin
                            ex_mode_d = 1'b0;
                            state_d = S_REC;
                        end
                        else
                        begin
                            seq_count_reg_d = nxt;
                            if (nxt[23:3] != seq_count_reg_q[23:3])
                                bval_d[seq_count_reg_q[BUF_BIT]] = 1'b0;
                        end
                    end
                end
            end
            S_BRW:
                if (is_ex_q)
                begin
                    if (land_v_q)
                    begin
                        ex_mode_d = 1'b1;
                        state_d = S_DEC;
                    end
                end
                else if (tests_done)
                begin
                    outc_c = 1'b1;
                    state_d = S_DEC;
                    if (branch_ok)
                    begin
                        seq_count_reg_d = adv(jt_q, 3'h0);
                        ex_mode_d = 1'b0;
                        bval_d = 2'h0;
                        s_take_d = 1'b1;
                        land_v_d = 1'b0;
                        if (land_v_q || (ret_valid && ret_kind == K_BR))
                        begin
                            buf_d[jt_q[BUF_BIT]] = land_v_q ? land_q
                                                            : ret_data;
                            bval_d[jt_q[BUF_BIT]] = 1'b1;
                        end
                        else
                            br_dir_d = 1'b1;
                    end
                    else
                    begin
                        land_v_d = 1'b0;
                        s_take_d = 1'b0;
                        if (ex_mode_q)
                        begin
                            ex_mode_d = 1'b0;
                            state_d = S_REC;
                        end
                    end
                end
            S_REC:
            begin
                seq_count_reg_d = adv(seq_count_reg_q, ex_len_q);
                if (seq_count_reg_d[23:3] != seq_count_reg_q[23:3])
                    bval_d[seq_count_reg_q[BUF_BIT]] = 1'b0;
                state_d = S_DEC;
            end
            default: ;
        endcase
        if (!rq_v_d)
        begin
            if (op_pend_q)
            begin
                rq_v_d = 1'b1;
                rq_kind_d = op_kind_q;
                rq_addr_d = op_addr_q;
                rq_buf_d = op_addr_q[BUF_BIT];
                op_pend_d = 1'b0;
            end
            else if (succ_pend_q)
            begin
                rq_v_d = 1'b1;
                rq_kind_d = K_SUCC;
                rq_addr_d = succ_addr_q;
                rq_buf_d = ~jt_q[BUF_BIT];
                succ_pend_d = 1'b0;
            end
            else if (seq_want)
            begin
                seq_issue = 1'b1;
                rq_v_d = 1'b1;
                rq_kind_d = K_SEQ;
                rq_addr_d = seq_a;
                rq_buf_d = seq_tgt;
                sbusy_d[seq_tgt] = 1'b1;
            end
        end
        if (ic_load)
        begin
            seq_count_reg_d = {ic_load_addr[23:1], 1'b0};
            bval_d = 2'h0;
            sbusy_d = 2'h0;
            land_v_d = 1'b0;
            ex_mode_d = 1'b0;
            br_dir_d = 1'b0;
            s_take_d = 1'b0;
            iop_ok_d = 1'b0;
            state_d = S_DEC;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            // Cleared so gate selection never reads unknown words
            buf_q <= '{64'h0, 64'h0};
            bval_q <= 2'h0;    sbusy_q <= 2'h0;
            land_v_q <= 1'b0;  iop_ok_q <= 1'b0;
            op_pend_q <= 1'b0; succ_pend_q <= 1'b0;
            rq_v_q <= 1'b0;    rq_kind_q <= K_NONE;
            op_kind_q <= K_NONE;
            entry_q <= 1'b0;   is_ex_q <= 1'b0;
            ex_mode_q <= 1'b0; br_dir_q <= 1'b0;
            s_take_q <= 1'b0;  ex_len_q <= 3'h0;
            seq_count_reg_q <= 24'h0;
            exec_op_reg_q <= 8'h0;
            last_cycle_op_reg_q <= 8'h0;
            sar_q <= 24'h0;    obl_q <= 64'h0;
            rq_addr_q <= 24'h0; rq_buf_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;   bval_q <= bval_d;
            buf_q <= buf_d;
            sbusy_q <= sbusy_d;   land_v_q <= land_v_d;
            iop_ok_q <= iop_ok_d; op_pend_q <= op_pend_d;
            succ_pend_q <= succ_pend_d;
            rq_v_q <= rq_v_d;     rq_kind_q <= rq_kind_d;
            op_kind_q <= op_kind_d;
            entry_q <= entry_d;   is_ex_q <= is_ex_d;
            ex_mode_q <= ex_mode_d; br_dir_q <= br_dir_d;
            s_take_q <= s_take_d; ex_len_q <= ex_len_d;
            seq_count_reg_q <= seq_count_reg_d;
            exec_op_reg_q <= exec_op_reg_d;
            last_cycle_op_reg_q <= last_cycle_op_reg_d;
            sar_q <= sar_d;       obl_q <= obl_d;
            rq_addr_q <= rq_addr_d; rq_buf_q <= rq_buf_d;
        end
    end

    // Data holders that need no reset value
    always_ff @(posedge clock)
    begin
        land_q <= land_d;
        instr_op_reg_q <= instr_op_reg_d;
        buffer_op_reg_q <= buffer_op_reg_d;
        jt_q <= jt_d;         op_addr_q <= op_addr_d;
        succ_addr_q <= succ_addr_d;
    end

    assign decode_phase        = state_q == S_DEC;
    assign address_phase       = state_q == S_ADR;
    assign address_phase_entry = address_phase && entry_q;
    assign exec_start    = start_c;
    assign outcome_ready = outc_c;
    assign exec_op       = exec_op_reg_q;
    assign last_cycle_op = last_cycle_op_reg_q;
    assign storage_addr  = sar_q;
    assign operand_bus_latch = obl_q;
    assign seq_count = seq_count_reg_q;
    assign req_valid = rq_v_q;
    assign req_kind  = rq_kind_q;
    assign req_addr  = rq_addr_q;
    assign req_buf   = rq_buf_q;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_ctr_bit_zero: assert property (seq_count_reg_q[0] == 1'b0)
        else $error("counter low bit set");
    a_iop_copy: assert property (decode_phase && !iop_ok_q && !ex_mode_q
        && !ic_load |=> instr_op_reg_q == $past(pick_n))
        else $error("instr op reg not loaded from gates");
    a_entry_sar: assert property (address_phase_entry
        && cur_cls != C_RR |=> sar_q == $past(ea))
        else $error("storage addr not loaded at entry");
    a_handoff_op: assert property (start_c
        |-> !intr_pending ##1 exec_op_reg_q == $past(buffer_op_reg_q))
        else $error("bad op hand-off");
    a_last_cycle_op_reg_copy: assert property (exec_last
        |=> last_cycle_op_reg_q == $past(exec_op_reg_q))
        else $error("last cycle op not captured");
    a_split_adv: assert property (start_c && cur_cls inside {C_RR, C_RX}
        && !ex_mode_q && !ic_load
        |=> seq_count_reg_q == $past(nxt))
        else $error("counter advance wrong");
    a_seq_cancel: assert property (rq_v_q && rq_kind_q == K_SEQ
        && exec_block && !req_ack
        |=> !(rq_v_q && rq_kind_q == K_SEQ))
        else $error("blocked fetch not cancelled");
    a_seq_quiet: assert property (seq_issue |-> state_q != S_BRW)
        else $error("fetch during branch wait");
    a_seq_bit20: assert property (seq_issue
        |=> rq_addr_q[BUF_BIT] == rq_buf_q)
        else $error("fetch bit20 mismatch");
    a_succ_opp: assert property (start_c && cur_cls == C_BR
        |=> succ_pend_q && succ_addr_q[23:3] == jt_q[23:3] + 21'h1)
        else $error("successor fetch wrong");
    a_br_taken: assert property (outc_c && branch_ok && !ic_load
        |=> seq_count_reg_q == {$past(jt_q[23:1]), 1'b0}
            && decode_phase)
        else $error("taken branch counter wrong");

    c_handoff: cover property (start_c);
    c_taken: cover property (outc_c && branch_ok);
    c_recover: cover property (state_q == S_REC);
endmodule

/* File: logic/ifb_pkg.sv */
// Constants and types for the instruction fetch and branch control
package ifb_pkg;
    localparam int AW      = 24;
    localparam int DW      = 64;
    localparam int BUF_BIT = 3;
    localparam int GS_HI   = 3;
    localparam int GS_LO   = 1;
    localparam int UP_LO   = 4;
    localparam logic [2:0] LEN_RR = 3'h2;
    localparam logic [2:0] LEN_RX = 3'h4;
    localparam logic [2:0] LEN_SS = 3'h6;
    localparam logic [7:0] OP_EX  = 8'h44;
    localparam logic [7:0] OP_BAL = 8'h45;
    localparam logic [7:0] OP_BCT = 8'h46;
    localparam logic [7:0] OP_BC  = 8'h47;
    typedef enum logic [2:0] {
        K_NONE, K_OPND, K_BR, K_SUCC, K_SEQ
    } ifb_kind_t;
    typedef enum logic [1:0] {
        C_RR, C_RX, C_BR, C_EX
    } ifb_class_t;
    typedef enum {S_IDLE, S_DEC, S_ADR, S_BRW, S_REC} ifb_state_t;
endpackage

/* File: verification/ifb_bus_model.sv */
// Behavioural bus control unit and storage behind the fetch controller
`timescale 1ns/1ps
module ifb_bus_model (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic [63:0]        mem_word,
    input  wire logic               req_valid,
    input  wire ifb_pkg::ifb_kind_t req_kind,
    input  wire logic               req_buf,
    output logic                    req_ack,
    output logic                    ret_valid,
    output ifb_pkg::ifb_kind_t      ret_kind,
    output logic                    ret_buf,
    output logic [63:0]             ret_data
);
    import ifb_pkg::*;
    logic [1:0] wait_q;
    always_ff @(posedge clock)
    begin
        ret_valid <= 1'b0;
        ret_data  <= ~ret_data;
        if (rst)
        begin
            req_ack  <= 1'b0;
            wait_q   <= 2'h0;
            ret_data <= 64'h0;
        end
        else if (req_valid && req_ack)
        begin
            // Every acknowledged request returns the word that the bench has staged
            req_ack   <= 1'b0;
            ret_valid <= 1'b1;
            ret_kind  <= req_kind;
            ret_buf   <= req_buf;
            ret_data  <= mem_word;
        end
        else if (req_valid)
        begin
            wait_q  <= wait_q + 2'h1;
            req_ack <= (wait_q == 2'h2);
        end
        else
            req_ack <= 1'b0;
    end
endmodule

/* File: verification/ifb_fetch_ctrl_tb_top.sv */
// Self-checking bench for the fetch and branch controller
`timescale 1ns/1ps
module ifb_fetch_ctrl_tb_top;
    import ifb_pkg::*;
    logic clock, rst, ic_load, intr_pending, exec_ready, exec_last;
    logic exec_block, tests_done, branch_ok, req_valid, req_buf, req_ack;
    logic ret_valid, ret_buf, decode_phase, address_phase, exec_start;
    logic [23:0] ic_load_addr, req_addr, seq_count, storage_addr;
    logic [63:0] opnd_data, ret_data, operand_bus_latch, mem_word;
    logic [7:0]  exec_op, last_cycle_op;
    ifb_kind_t   req_kind, ret_kind;
    int num_errors = 0;
    int checks = 0;
    bit got;
    ifb_fetch_ctrl u_dut (.clock(clock), .rst(rst), .ic_load(ic_load),
        .ic_load_addr(ic_load_addr), .intr_pending(intr_pending),
        .exec_ready(exec_ready), .exec_last(exec_last),
        .exec_block(exec_block), .tests_done(tests_done),
        .branch_ok(branch_ok), .base_sel(), .index_sel(),
        .base_data(24'h000100), .index_data(24'h000020), .opnd_sel(),
        .opnd_float(), .opnd_data(opnd_data), .req_valid(req_valid),
        .req_kind(req_kind), .req_addr(req_addr), .req_buf(req_buf),
        .req_ack(req_ack), .ret_valid(ret_valid), .ret_kind(ret_kind),
        .ret_buf(ret_buf), .ret_data(ret_data),
        .decode_phase(decode_phase), .address_phase(address_phase),
        .address_phase_entry(), .exec_start(exec_start),
        .exec_op(exec_op), .last_cycle_op(last_cycle_op),
        .outcome_ready(), .storage_addr(storage_addr),
        .operand_bus_latch(operand_bus_latch), .seq_count(seq_count));
    ifb_bus_model u_bus (.clock(clock), .rst(rst), .mem_word(mem_word),
        .req_valid(req_valid),
        .req_kind(req_kind), .req_buf(req_buf), .req_ack(req_ack),
        .ret_valid(ret_valid), .ret_kind(ret_kind), .ret_buf(ret_buf),
        .ret_data(ret_data));
    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_start(int lim);
        got = 0;
        repeat (lim)
        begin
            @(negedge clock);
            if (exec_start === 1'b1)
            begin
                got = 1;
                break;
            end
        end
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        end_of_test();
    end
    initial
    begin
        {ic_load, intr_pending, exec_block, tests_done, branch_ok} = 5'h00;
        {exec_ready, exec_last, rst} = 3'h7;
        ic_load_addr = 24'h001001;
        opnd_data = 64'h0123456789abcdef;
        mem_word = {4{16'h1812}};
        repeat (8) @(negedge clock);
        rst = 0;
        chk("idle", {decode_phase, address_phase, req_valid}, 64'h0);
        chk("seq_count", seq_count, 64'h0);
        ic_load = 1;
        @(negedge clock);
        ic_load = 0;
        chk("seq_count", seq_count, 64'h001000);
        repeat (4) @(negedge clock);
        chk("req_kind", req_kind, K_SEQ);
        chk("req_addr", req_addr, 64'h001000);
        chk("req_buf", req_buf, 64'h0);
        wait_start(200);
        chk("exec_start", got, 64'h1);
        @(negedge clock);
        intr_pending = 1;
        chk("exec_op", exec_op, 64'h18);
        chk("operand_bus_latch", operand_bus_latch, opnd_data);
        @(negedge clock);
        chk("last_cycle_op", last_cycle_op, 64'h18);
        wait_start(60);
        chk("blocked_start", got, 64'h0);
        chk("phases", {decode_phase, address_phase}, 64'h0);
        // Restart with fetches blocked, then cancel one unacknowledged
        {exec_block, intr_pending, ic_load} = 3'h5;
        ic_load_addr = 24'h002000;
        @(negedge clock);
        ic_load = 0;
        @(negedge clock);
        chk("blocked_req", req_valid, 64'h0);
        exec_block = 0;
        @(negedge clock);
        chk("req_valid", req_valid, 64'h1);
        chk("req_addr", req_addr, 64'h002000);
        exec_block = 1;
        @(negedge clock);
        chk("cancelled_req", req_valid, 64'h0);
        // Taken branch: base 1 plus displacement 010 gives target 110
        mem_word = 64'h47f0101047f01010;
        ic_load = 1;
        ic_load_addr = 24'h000200;
        @(negedge clock);
        {ic_load, exec_block} = 2'h0;
        wait_start(100);
        chk("branch_start", got, 64'h1);
        @(negedge clock);
        chk("exec_op", exec_op, 64'h47);
        chk("storage_addr", storage_addr, 64'h000110);
        {tests_done, branch_ok} = 2'h3;
        @(negedge clock);
        {tests_done, branch_ok} = 2'h0;
        chk("seq_count", seq_count, 64'h000110);
        chk("decode_phase", decode_phase, 64'h1);
        end_of_test();
    end
endmodule
